// [core/ssdr_pkg.sv]
// constants, types and register map of the serial status/data block
// Notes on behaviour
// - tx empty request raised only while transmit interrupt enable is 1
// - rx full flag cleared by writing 0 after reading it as 1
// - good reception moves byte to receive buffer and sets rx full
// - overrun set when a frame completes while rx full is still 1
// - framing flag set when the received stop bit is 0
// - parity flag set when ones count disagrees with chosen parity
// - tx end reads 0 while sending; cleared by flag write or data write
// - tx end set when transmit disabled or last bit sent with empty
// - tx empty cleared by write 0 after read 1 or data write
// - tx empty set when transmit disabled or buffer moved to shifter
// - multiprocessor bit sent from software bit, captured on receive
// - mp wait mode drops frames and requests, parity flag aside, until mp bit 1 arrives
// - rx full and rx error requests gated by receive interrupt enable
// - tx end request raised only while its enable is 1
package ssdr_pkg;
  localparam int unsigned CLK_HZ    = 10_000_000;
  localparam int unsigned BAUD_BPS  = 625_000;
  localparam int unsigned BIT_CYC   = CLK_HZ / BAUD_BPS;
  localparam logic [3:0]  BIT_LAST  = 4'(BIT_CYC - 1);
  localparam logic [3:0]  HALF_LAST = 4'(BIT_CYC / 2 - 1);
  localparam int unsigned AW        = 12;
  // register byte addresses
  localparam logic [AW-1:0] ADR_CTL = 12'h000;
  localparam logic [AW-1:0] ADR_STA = 12'h004;
  localparam logic [AW-1:0] ADR_TDB = 12'h008;
  localparam logic [AW-1:0] ADR_RDB = 12'h00C;
  localparam logic [AW-1:0] ADR_IST = 12'h010;
  localparam logic [AW-1:0] ADR_IMK = 12'h014;
  // reset values
  localparam logic [7:0] TDB_RST = 8'hFF;
  localparam logic [7:0] RDB_RST = 8'h00;
  localparam logic [7:0] STA_RST = 8'h84;
  // status bit positions
  localparam int unsigned ST_EMPTY = 7;
  localparam int unsigned ST_FULL  = 6;
  localparam int unsigned ST_PER   = 3;
  // interrupt status bit positions
  localparam int unsigned IV_TXE = 0;
  localparam int unsigned IV_TND = 1;
  localparam int unsigned IV_RXF = 2;
  localparam int unsigned IV_ERR = 3;
  // control register layout, bit 10 down to 2
  typedef struct packed {
    logic mp_mode;
    logic par_odd;
    logic par_en;
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic tx_enable_bit;
    logic rx_enable;
    logic mp_irq_enable;
    logic tx_end_irq_enable;
  } ssdr_ctl_s;
  localparam int unsigned CTL_LSB = 2;
  // status register layout, bit 7 down to 0
  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    logic tx_end_flag;
    logic mp_bit_received;
    logic mp_bit_to_send;
  } ssdr_sta_s;
  // one finished reception
  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic       perr;
    logic       ferr;
    logic       mpb;
  } ssdr_rx_s;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ssdr_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ssdr_rx_e;
endpackage

// [core/ssdr_rx.sv]
// receive frame engine with pin synchroniser
`timescale 1ns/10ps
module ssdr_rx (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic           rxd,
  input  wire logic           en,
  input  wire logic           par_en,
  input  wire logic           par_odd,
  input  wire logic           mp_mode,
  output ssdr_pkg::ssdr_rx_s  rx
);
  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              s3;
    logic              lvl;
    ssdr_pkg::ssdr_rx_e st;
    logic [3:0]        cnt;
    logic [3:0]        idx;
    logic [10:0]       sh;
    logic              done;
  } ssdr_rxst_s;
  ssdr_rxst_s q_r, q_nxt;
  logic [3:0] last_idx;
  logic [3:0] p_idx;
  logic [3:0] m_idx;

  // bit positions behind the data byte, last_idx is the stop bit
  assign p_idx    = 4'd8;
  assign m_idx    = 4'd8 + {3'b000, par_en};
  assign last_idx = m_idx + {3'b000, mp_mode};

  // sync chain, start hunt and bit sampling
  always_comb begin
    q_nxt      = q_r;
    q_nxt.s1   = rxd;
    q_nxt.s2   = q_r.s1;
    q_nxt.s3   = q_r.s2;
    q_nxt.done = 1'b0;
    if (q_r.s2 == q_r.s3) q_nxt.lvl = q_r.s3;
    q_nxt.cnt = q_r.cnt - 4'd1;
    case (q_r.st)
      ssdr_pkg::RX_IDLE: begin
        q_nxt.cnt = ssdr_pkg::HALF_LAST;
        if (en && !q_r.lvl) q_nxt.st = ssdr_pkg::RX_START;
      end
      ssdr_pkg::RX_START: begin
        if (q_r.cnt == 4'd0) begin
          q_nxt.cnt = ssdr_pkg::BIT_LAST;
          q_nxt.idx = 4'd0;
          q_nxt.st  = q_r.lvl ? ssdr_pkg::RX_IDLE : ssdr_pkg::RX_BITS;
        end
      end
      ssdr_pkg::RX_BITS: begin
        if (q_r.cnt == 4'd0) begin
          q_nxt.sh[q_r.idx] = q_r.lvl;
          q_nxt.cnt = ssdr_pkg::BIT_LAST;
          q_nxt.idx = q_r.idx + 4'd1;
          if (q_r.idx == last_idx) begin
            q_nxt.done = 1'b1;
            q_nxt.st   = ssdr_pkg::RX_IDLE;
          end
        end
      end
      default: q_nxt.st = ssdr_pkg::RX_IDLE;
    endcase
    if (!en) q_nxt.st = ssdr_pkg::RX_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r     <= '0;
      q_r.s1  <= 1'b1;
      q_r.s2  <= 1'b1;
      q_r.s3  <= 1'b1;
      q_r.lvl <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // decoded frame, stable after done
  always_comb begin
    rx.done = q_r.done;
    rx.data = q_r.sh[7:0];
    rx.perr = par_en && ((^q_r.sh[7:0] ^ q_r.sh[p_idx]) != par_odd);
    rx.ferr = !q_r.sh[last_idx];
    rx.mpb  = mp_mode && q_r.sh[m_idx];
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_frame_len;
    $rose(q_r.st == ssdr_pkg::RX_BITS) |-> !q_r.done [*8];
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("rx early done");
endmodule

// [core/ssdr_top.sv]
// serial status flags, data buffers, transmitter and apb slave
`timescale 1ns/10ps
module ssdr_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ssdr_pkg::AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    rxd,
  output logic                         txd,
  output logic                         tx_empty_irq,
  output logic                         tx_end_irq,
  output logic                         rx_full_irq,
  output logic                         rx_err_irq,
  output logic                         irq
);
  typedef struct packed {
    ssdr_pkg::ssdr_ctl_s ctl;
    ssdr_pkg::ssdr_sta_s sta;
    logic [4:0]          seen;
    logic [7:0]          tdb;
    logic [7:0]          rdb;
    logic [3:0]          ist;
    logic [3:0]          imk;
    ssdr_pkg::ssdr_tx_e  txs;
    logic [10:0]         tsh;
    logic [3:0]          tcnt;
    logic [3:0]          tbit;
    logic                txd;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [3:0]          req;
    logic                irq;
  } ssdr_st_s;
  ssdr_st_s q_r, q_nxt;
  ssdr_pkg::ssdr_rx_s rx;

  // register address match
  function automatic logic hit(input logic [ssdr_pkg::AW-1:0] a,
                               input logic [ssdr_pkg::AW-1:0] r);
    hit = (a == r);
  endfunction

  // serial frame, lsb first, unused tail kept high
  function automatic logic [10:0] frame(input logic [7:0] d,
                                        input ssdr_pkg::ssdr_ctl_s c,
                                        input logic mp);
    logic par;
    logic [2:0] tail;
    par = ^d ^ c.par_odd;
    case ({c.par_en, c.mp_mode})
      2'b10:   tail = {2'b11, par};
      2'b01:   tail = {2'b11, mp};
      2'b11:   tail = {1'b1, mp, par};
      default: tail = 3'b111;
    endcase
    frame = {tail[1:0], d, 1'b0}; // top tail bit comes from shift-in
  endfunction

  ssdr_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .rxd     (rxd),
    .en      (q_r.ctl.rx_enable),
    .par_en  (q_r.ctl.par_en),
    .par_odd (q_r.ctl.par_odd),
    .mp_mode (q_r.ctl.mp_mode),
    .rx      (rx)
  );

  logic acc;
  logic wr;
  logic rd;
  logic tdb_wr;
  logic accept;
  logic [3:0] tlen;
  logic [7:0] stw;
  logic [7:0] str;
  logic [3:0] ev;

  assign acc    = psel && penable && q_r.pready;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  assign tdb_wr = wr && hit(paddr, ssdr_pkg::ADR_TDB);
  assign stw    = pwdata[7:0];
  assign str    = q_r.prdata[7:0];
  // mp wait drops frames whose mp bit is 0
  assign accept = !q_r.ctl.mp_irq_enable || rx.mpb;
  assign tlen   = 4'd9 + {3'b000, q_r.ctl.par_en}
                + {3'b000, q_r.ctl.mp_mode};

  // next state of registers, flags, transmitter and bus
  always_comb begin
    q_nxt         = q_r;
    q_nxt.pready  = psel && !penable;
    q_nxt.pslverr = 1'b0;
    // read data snapshot at setup
    if (psel && !penable) begin
      q_nxt.prdata = 32'h0000_0000;
      case (1'b1)
        hit(paddr, ssdr_pkg::ADR_CTL):
          q_nxt.prdata[10:ssdr_pkg::CTL_LSB] = q_r.ctl;
        hit(paddr, ssdr_pkg::ADR_STA): q_nxt.prdata[7:0] = q_r.sta;
        hit(paddr, ssdr_pkg::ADR_TDB): q_nxt.prdata[7:0] = q_r.tdb;
        hit(paddr, ssdr_pkg::ADR_RDB): q_nxt.prdata[7:0] = q_r.rdb;
        hit(paddr, ssdr_pkg::ADR_IST): q_nxt.prdata[3:0] = q_r.ist;
        hit(paddr, ssdr_pkg::ADR_IMK): q_nxt.prdata[3:0] = q_r.imk;
        default: q_nxt.pslverr = 1'b1;
      endcase
    end
    if (rd && hit(paddr, ssdr_pkg::ADR_STA))
      q_nxt.seen = q_r.seen | str[7:ssdr_pkg::ST_PER];
    // register writes
    if (wr) begin
      if (hit(paddr, ssdr_pkg::ADR_CTL))
        q_nxt.ctl = pwdata[10:ssdr_pkg::CTL_LSB];
      if (hit(paddr, ssdr_pkg::ADR_IMK)) q_nxt.imk = pwdata[3:0];
      if (hit(paddr, ssdr_pkg::ADR_STA)) begin
        q_nxt.sta.mp_bit_to_send = stw[0];
        // write 0 after read 1 clears, write 1 ignored
        q_nxt.sta[7:ssdr_pkg::ST_PER] = q_r.sta[7:ssdr_pkg::ST_PER]
                                      & (stw[7:ssdr_pkg::ST_PER]
                                      | ~q_r.seen);
        // tx end cleared with tx empty
        if (q_r.seen[4] && !stw[ssdr_pkg::ST_EMPTY])
          q_nxt.sta.tx_end_flag = 1'b0;
      end
    end
    if (tdb_wr) begin
      q_nxt.tdb                = stw;
      q_nxt.sta.tx_empty_flag  = 1'b0;
      q_nxt.sta.tx_end_flag    = 1'b0;
    end
    // transmitter
    q_nxt.tcnt = q_r.tcnt - 4'd1;
    case (q_r.txs)
      ssdr_pkg::TX_IDLE: begin
        q_nxt.txd = 1'b1;
        if (q_r.ctl.tx_enable_bit && !q_r.sta.tx_empty_flag
            && !tdb_wr) begin
          // mp bit goes out with the frame
          q_nxt.tsh  = frame(q_r.tdb, q_r.ctl, q_r.sta.mp_bit_to_send);
          q_nxt.tcnt = ssdr_pkg::BIT_LAST;
          q_nxt.tbit = 4'd0;
          q_nxt.txs  = ssdr_pkg::TX_SHIFT;
          q_nxt.txd  = 1'b0;
          q_nxt.sta.tx_empty_flag = 1'b1;
          q_nxt.sta.tx_end_flag   = 1'b0;
        end
      end
      ssdr_pkg::TX_SHIFT: begin
        if (q_r.tcnt == 4'd0) begin
          q_nxt.tcnt = ssdr_pkg::BIT_LAST;
          q_nxt.tbit = q_r.tbit + 4'd1;
          q_nxt.tsh  = {1'b1, q_r.tsh[10:1]};
          q_nxt.txd  = q_r.tsh[1];
          if (q_r.tbit == tlen) begin
            q_nxt.txs = ssdr_pkg::TX_IDLE;
            q_nxt.txd = 1'b1;
            // last bit sent with buffer empty
            if (q_nxt.sta.tx_empty_flag) q_nxt.sta.tx_end_flag = 1'b1;
          end
        end
      end
      default: q_nxt.txs = ssdr_pkg::TX_IDLE;
    endcase
    if (!q_nxt.ctl.tx_enable_bit) begin
      q_nxt.txs               = ssdr_pkg::TX_IDLE;
      q_nxt.txd               = 1'b1;
      q_nxt.sta.tx_empty_flag = 1'b1;
      q_nxt.sta.tx_end_flag   = 1'b1;
    end
    // receive completion, hardware set wins over clear
    if (rx.done) begin
      q_nxt.sta.mp_bit_received = rx.mpb;
      if (q_r.ctl.mp_irq_enable && rx.mpb)
        q_nxt.ctl.mp_irq_enable = 1'b0;
      if (accept) begin
        if (q_r.sta.rx_full_flag) begin
          q_nxt.sta.overrun_flag = 1'b1;
        end else if (!rx.ferr && !rx.perr) begin
          q_nxt.rdb              = rx.data;
          q_nxt.sta.rx_full_flag = 1'b1;
        end
        if (rx.ferr) q_nxt.sta.framing_flag = 1'b1;
      end
      if (rx.perr) q_nxt.sta.parity_flag = 1'b1;
    end
    // seen bits drop with their flags
    q_nxt.seen = q_nxt.seen & q_nxt.sta[7:ssdr_pkg::ST_PER];
    q_nxt.req[ssdr_pkg::IV_TXE] = q_nxt.sta.tx_empty_flag
                                && q_nxt.ctl.tx_irq_enable;
    q_nxt.req[ssdr_pkg::IV_TND] = q_nxt.sta.tx_end_flag
                                && q_nxt.ctl.tx_end_irq_enable;
    q_nxt.req[ssdr_pkg::IV_RXF] = q_nxt.sta.rx_full_flag
                                && q_nxt.ctl.rx_irq_enable;
    q_nxt.req[ssdr_pkg::IV_ERR] = (q_nxt.sta.overrun_flag
                                || q_nxt.sta.framing_flag
                                || q_nxt.sta.parity_flag)
                                && q_nxt.ctl.rx_irq_enable;
    // sticky status, cleared by read, new event wins
    ev = q_nxt.req & ~q_r.req;
    if (rd && hit(paddr, ssdr_pkg::ADR_IST)) q_nxt.ist = 4'h0;
    q_nxt.ist = q_nxt.ist | ev;
    q_nxt.irq = |(q_nxt.ist & q_nxt.imk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r     <= '0;
      q_r.tdb <= ssdr_pkg::TDB_RST;
      q_r.rdb <= ssdr_pkg::RDB_RST;
      q_r.sta <= ssdr_pkg::STA_RST;
      q_r.txd <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from state
  assign prdata       = q_r.prdata;
  assign pready       = q_r.pready;
  assign pslverr      = q_r.pslverr;
  assign txd          = q_r.txd;
  assign tx_empty_irq = q_r.req[ssdr_pkg::IV_TXE];
  assign tx_end_irq   = q_r.req[ssdr_pkg::IV_TND];
  assign rx_full_irq  = q_r.req[ssdr_pkg::IV_RXF];
  assign rx_err_irq   = q_r.req[ssdr_pkg::IV_ERR];
  assign irq          = q_r.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tdb_wr;
    tdb_wr && q_r.ctl.tx_enable_bit
      && q_r.txs == ssdr_pkg::TX_IDLE;
  endsequence
  sequence s_te_fall;
    $fell(q_r.ctl.tx_enable_bit);
  endsequence
  sequence s_rx_good;
    rx.done && accept && !q_r.sta.rx_full_flag && !rx.ferr && !rx.perr;
  endsequence

  property p_txi_gate;
    tx_empty_irq |-> q_r.ctl.tx_irq_enable && q_r.sta.tx_empty_flag;
  endproperty
  a_txi_gate: assert property (p_txi_gate) else $error("txi ungated");
  property p_rx_load;
    s_rx_good |=> q_r.sta.rx_full_flag
                  && q_r.rdb == $past(rx.data);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx not loaded");
  property p_ovr;
    rx.done && accept && q_r.sta.rx_full_flag
      |=> q_r.sta.overrun_flag && $stable(q_r.rdb);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");
  property p_fer;
    rx.done && accept && rx.ferr |=> q_r.sta.framing_flag;
  endproperty
  a_fer: assert property (p_fer) else $error("framing missed");
  property p_wr_clr;
    s_tdb_wr |=> !q_r.sta.tx_empty_flag && !q_r.sta.tx_end_flag
                 ##1 q_r.txs == ssdr_pkg::TX_SHIFT
                     || !q_r.ctl.tx_enable_bit;
  endproperty
  a_wr_clr: assert property (p_wr_clr) else $error("write no clear");
  property p_te_off;
    s_te_fall |-> q_r.sta.tx_empty_flag && q_r.sta.tx_end_flag && txd;
  endproperty
  a_te_off: assert property (p_te_off) else $error("te off flags");
  property p_mp_drop;
    rx.done && q_r.ctl.mp_irq_enable && !rx.mpb
      |=> !$rose(q_r.sta.rx_full_flag) && !$rose(q_r.sta.overrun_flag);
  endproperty
  a_mp_drop: assert property (p_mp_drop) else $error("mp not dropped");
  property p_rx_gate;
    (rx_full_irq || rx_err_irq) |-> q_r.ctl.rx_irq_enable;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx req ungated");
  property p_tei_gate;
    tx_end_irq |-> q_r.ctl.tx_end_irq_enable && q_r.sta.tx_end_flag;
  endproperty
  a_tei_gate: assert property (p_tei_gate) else $error("tei ungated");
  property p_busy;
    q_r.txs == ssdr_pkg::TX_SHIFT |-> !q_r.sta.tx_end_flag;
  endproperty
  a_busy: assert property (p_busy) else $error("end while busy");
endmodule

// [bench/ssdr_peer.sv]
// remote serial transceiver model facing the serial status block
`timescale 1ns/10ps
module ssdr_peer (
  input  wire logic       pclk,
  input  wire logic       txd,
  input  wire logic       par_en,
  input  wire logic       mp_mode,
  output logic            rxd,
  output logic [7:0]      got_data,
  output logic            got_mpb,
  output int              got_cnt
);
  localparam int BITC = 16; // clocks per bit at the fixed rate

  // line idles high, nothing captured yet
  initial begin
    rxd = 1'b1;
    got_data = 8'h00;
    got_mpb = 1'b0;
    got_cnt = 0;
  end

  // one frame onto the line; bad_par and bad_stop corrupt it on purpose
  task automatic send(input logic [7:0] d, input logic mpb,
                      input logic odd, input logic bad_par,
                      input logic bad_stop);
    logic q[$];
    q.push_back(1'b0);
    for (int i = 0; i < 8; i++) q.push_back(d[i]);
    if (par_en) q.push_back(^d ^ odd ^ bad_par);
    if (mp_mode) q.push_back(mpb);
    q.push_back(~bad_stop);
    q.push_back(1'b1);
    foreach (q[i]) begin
      @(posedge pclk);
      rxd <= q[i];
      repeat (BITC - 1) @(posedge pclk);
    end
  endtask

  // capture frames from the transmit line, sampled mid bit
  always begin
    @(negedge txd);
    repeat (BITC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BITC) @(posedge pclk);
      got_data[i] = txd;
    end
    if (par_en) repeat (BITC) @(posedge pclk);
    if (mp_mode) begin
      repeat (BITC) @(posedge pclk);
      got_mpb = txd;
    end
    repeat (BITC) @(posedge pclk);
    got_cnt++;
  end
endmodule

// [bench/ssdr_top_test.sv]
// self-checking bench for the serial status and data block
`timescale 1ns/10ps
module ssdr_top_test;
  logic                    pclk, presetn, psel, penable, pwrite;
  logic [ssdr_pkg::AW-1:0] paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic                    pready, pslverr, rxd, txd, err_seen;
  logic                    tx_empty_irq, tx_end_irq, rx_full_irq;
  logic                    rx_err_irq, irq, par_en, mp_mode, got_mpb;
  logic [7:0]              got_data;
  int                      got_cnt, errors, checks_done;

  ssdr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
    .rx_full_irq(rx_full_irq), .rx_err_irq(rx_err_irq), .irq(irq));

  ssdr_peer peer_u (.pclk(pclk), .txd(txd), .par_en(par_en),
    .mp_mode(mp_mode), .rxd(rxd), .got_data(got_data),
    .got_mpb(got_mpb), .got_cnt(got_cnt));

  // 100 ns clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // one apb transfer; read data lands in rd
  task automatic apb(input logic w, input logic [ssdr_pkg::AW-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // status read compared under a mask
  task automatic st(input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, ssdr_pkg::ADR_STA, 32'h0);
    chk("status", {24'h0, e}, rd & {24'h0, m});
  endtask

  // read status, then write 0 to the given flags
  task automatic clr(input logic [7:0] m);
    apb(1'b0, ssdr_pkg::ADR_STA, 32'h0);
    apb(1'b1, ssdr_pkg::ADR_STA, {24'h0, ~m & 8'hFE});
  endtask

  // frame from the peer, then let the flags settle
  task automatic rxf(input logic [7:0] d, input logic mpb,
                     input logic bp, input logic bs);
    peer_u.send(d, mpb, 1'b0, bp, bs);
    repeat (4) @(posedge pclk);
  endtask

  task automatic txw(input logic [7:0] d);
    int n;
    n = got_cnt;
    apb(1'b1, ssdr_pkg::ADR_TDB, {24'h0, d});
    // end low while sending, empty back after load
    st(8'h80, 8'hFC);
    while (got_cnt == n) @(posedge pclk);
    // let the stop bit finish before looking at the flags
    repeat (ssdr_pkg::BIT_CYC) @(posedge pclk);
    chk("tx data", {24'h0, d}, {24'h0, got_data});
  endtask

  task automatic t_reset;
    st(8'h84, 8'hFF);
    apb(1'b0, ssdr_pkg::ADR_TDB, 32'h0);
    chk("tx buffer", 32'hFF, rd);
    apb(1'b0, ssdr_pkg::ADR_RDB, 32'h0);
    chk("rx buffer", 32'h0, rd);
    apb(1'b0, 12'h018, 32'h0);
    chk("slverr", 32'h1, {31'h0, err_seen});
    chk("unmapped data", 32'h0, rd);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // transmit path, flags and irq gating
  task automatic t_tx;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'hA4);
    repeat (2) @(posedge pclk);
    chk("tx_empty_irq", 32'h1, {31'h0, tx_empty_irq});
    chk("tx_end_irq", 32'h1, {31'h0, tx_end_irq});
    apb(1'b1, ssdr_pkg::ADR_STA, 32'hFE);
    st(8'h84, 8'hFF);
    txw(8'hA5);
    st(8'h84, 8'hFC);
    mp_mode = 1'b1;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h4A4);
    apb(1'b1, ssdr_pkg::ADR_STA, 32'hFF);
    txw(8'h5A);
    chk("tx mp bit", 32'h1, {31'h0, got_mpb});
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h24);
    repeat (2) @(posedge pclk);
    chk("tx_empty_irq", 32'h0, {31'h0, tx_empty_irq});
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h0);
    mp_mode = 1'b0;
  endtask

  // receive flags, errors and their clearing
  task automatic t_rx;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h50);
    rxf(8'h3C, 1'b0, 1'b0, 1'b0);
    st(8'h40, 8'h78);
    chk("rx_full_irq", 32'h1, {31'h0, rx_full_irq});
    apb(1'b1, ssdr_pkg::ADR_RDB, 32'h55);
    rxf(8'hC3, 1'b0, 1'b0, 1'b0);
    st(8'h60, 8'h78);
    chk("rx_err_irq", 32'h1, {31'h0, rx_err_irq});
    apb(1'b0, ssdr_pkg::ADR_RDB, 32'h0);
    chk("rx buffer", 32'h3C, rd);
    clr(8'h60);
    st(8'h00, 8'h78);
    rxf(8'h11, 1'b0, 1'b0, 1'b1);
    st(8'h10, 8'h78);
    clr(8'h10);
    par_en = 1'b1;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h150);
    rxf(8'h22, 1'b0, 1'b1, 1'b0);
    st(8'h08, 8'h78);
    clr(8'h08);
    // odd parity, good frame is stored
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h350);
    peer_u.send(8'h22, 1'b0, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge pclk);
    st(8'h40, 8'h78);
    clr(8'h40);
    par_en = 1'b0;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h10);
    rxf(8'h44, 1'b0, 1'b0, 1'b0);
    st(8'h40, 8'h78);
    chk("rx_full_irq", 32'h0, {31'h0, rx_full_irq});
    clr(8'h40);
  endtask

  task automatic t_mp;
    mp_mode = 1'b1;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h458);
    rxf(8'h66, 1'b0, 1'b0, 1'b0);
    st(8'h00, 8'h7A);
    rxf(8'h77, 1'b1, 1'b0, 1'b0);
    st(8'h42, 8'h7A);
    apb(1'b0, ssdr_pkg::ADR_RDB, 32'h0);
    chk("rx buffer", 32'h77, rd);
    clr(8'h40);
    mp_mode = 1'b0;
  endtask

  // summary interrupt: sticky status, mask, read clear
  task automatic t_irq;
    apb(1'b1, ssdr_pkg::ADR_CTL, 32'h50);
    apb(1'b0, ssdr_pkg::ADR_IST, 32'h0);
    rxf(8'h99, 1'b0, 1'b0, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, ssdr_pkg::ADR_IST, 32'h0);
    chk("irq status", 32'h4, rd & 32'h4);
    clr(8'h40);
    apb(1'b1, ssdr_pkg::ADR_IMK, 32'h4);
    rxf(8'hAA, 1'b0, 1'b0, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, ssdr_pkg::ADR_IST, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim;
  end

  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    par_en = 1'b0;
    mp_mode = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_mp;
    t_irq;
    end_sim;
  end
endmodule
